// ---- design/ufsp_top.sv ----
// Purpose: serial port of a 512 x 16 user flash with two erase sectors
// Assumes: all port inputs come from outside the clock domain
// Notes: program and erase timed by counters; no boundary-scan logic

// Functional notes
// [RQ1] The array holds 512 words selected by a 9-bit address 000h-1FFh.
// [RQ2] Addresses 000h-0FFh are sector 0 and 100h-1FFh are sector 1.
// [RQ3] Each word is 16 bits; narrower widths are left to user logic.
// [RQ4] An erase clears exactly one sector, the one the address selects.
// [RQ5] User logic erases a sector before programming it; the other stays.
// [RQ6] A held program or erase request runs a self-timed algorithm.
// [RQ7] User logic holds the request until busy falls.
// [RQ8] Busy stays high during program or erase and falls at completion.
// [RQ9] An oscillator drives the operations and is exported divided by 4.
// [RQ10] The exported clock runs at a fixed rate inside 3.9-5.3 MHz.
// [RQ11] Both single-word reads and stream reads are supported.
// [RQ12] An address clock with shift control low increments the address.
// [RQ13] The address register is 9 bits and the data register 16 bits.
// [RQ14] A test-access path may also program and read the array.
// [RQ15] An address clock with shift control high shifts in one bit.
// [RQ16] Data clock loads the word when shift is low, shifts when high.
// [RQ17] The oscillator clock output runs only while enabled.
module ufsp_top #(
    parameter int PROG_CYCLES = ufsp_pkg::PROG_CYC,
    parameter int ERASE_CYCLES = ufsp_pkg::ERASE_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // address port
    input wire logic i_addr_shift_clk,
    input wire logic i_addr_shift_ctl,
    input wire logic i_addr_serial_in,
    // data port
    input wire logic i_data_shift_clk,
    input wire logic i_data_shift_ctl,
    input wire logic i_data_serial_in,
    output logic o_data_serial_out,
    // program and erase
    input wire logic i_program,
    input wire logic i_erase,
    output logic o_runtime_prog_busy,
    // oscillator
    input wire logic i_osc_enable,
    output logic o_osc_div_clk_out,
    // test-access path
    input wire logic i_tap_we,
    input wire logic [ufsp_pkg::ADDR_W-1:0] i_tap_addr,
    input wire logic [ufsp_pkg::DATA_W-1:0] i_tap_wdata,
    output logic [ufsp_pkg::DATA_W-1:0] o_tap_rdata
);
    localparam int AW = ufsp_pkg::ADDR_W;
    localparam int DW = ufsp_pkg::DATA_W;

    logic [DW-1:0] mem [ufsp_pkg::WORDS]; // [RQ1] [RQ3]
    logic [AW-1:0] addr; // [RQ13]
    logic [DW-1:0] data; // [RQ13]
    logic [AW-1:0] op_addr;
    logic [DW-1:0] op_data;
    logic [31:0] op_cnt;
    ufsp_pkg::ufsp_state_t state;
    logic ashift;
    logic aserial;
    logic aclk_rise;
    logic dshift;
    logic dserial;
    logic dclk_rise;
    logic prog_lvl;
    logic erase_lvl;
    logic tap_we_lvl;
    logic tap_we_rise;
    logic [AW-1:0] tap_addr_m;
    logic [AW-1:0] tap_addr_s;
    logic [DW-1:0] tap_wdata_m;
    logic [DW-1:0] tap_wdata_s;
    logic busy;
    logic op_done;
    logic [DW-1:0] data_out_q;
    logic osc_en_lvl;
    logic osc_out_q;
    logic erase_fire;
    logic prog_fire;

    ufsp_osc_if osc_link ();

    ufsp_osc u_osc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .osc(osc_link.gen)
    );

    // oscillator also runs while busy: the algorithms are timed on it
    assign osc_link.enable = osc_en_lvl | busy; // [RQ9]

    // exported clock leaves a flop so the enable gate cannot glitch it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            osc_out_q <= 1'b0;
        end else begin
            osc_out_q <= osc_link.clk_out & osc_en_lvl; // [RQ17]
        end
    end

    assign o_osc_div_clk_out = osc_out_q; // [RQ10]

    // pin synchronisers
    // ctl and serial pins share the clock pin's delay, so they stay aligned
    ufsp_edge u_aclk (
        .i_clk(i_clk), .i_rst(i_rst), .i_async(i_addr_shift_clk),
        .o_level(), .o_rise(aclk_rise)
    );
    ufsp_edge u_actl (
        .i_clk(i_clk), .i_rst(i_rst), .i_async(i_addr_shift_ctl),
        .o_level(ashift), .o_rise()
    );
    ufsp_edge u_ain (
        .i_clk(i_clk), .i_rst(i_rst), .i_async(i_addr_serial_in),
        .o_level(aserial), .o_rise()
    );
    ufsp_edge u_dclk (
        .i_clk(i_clk), .i_rst(i_rst), .i_async(i_data_shift_clk),
        .o_level(), .o_rise(dclk_rise)
    );
    ufsp_edge u_dctl (
        .i_clk(i_clk), .i_rst(i_rst), .i_async(i_data_shift_ctl),
        .o_level(dshift), .o_rise()
    );
    ufsp_edge u_din (
        .i_clk(i_clk), .i_rst(i_rst), .i_async(i_data_serial_in),
        .o_level(dserial), .o_rise()
    );
    ufsp_edge u_prog (
        .i_clk(i_clk), .i_rst(i_rst), .i_async(i_program),
        .o_level(prog_lvl), .o_rise()
    );
    ufsp_edge u_erase (
        .i_clk(i_clk), .i_rst(i_rst), .i_async(i_erase),
        .o_level(erase_lvl), .o_rise()
    );
    ufsp_edge u_tapwe (
        .i_clk(i_clk), .i_rst(i_rst), .i_async(i_tap_we),
        .o_level(tap_we_lvl), .o_rise(tap_we_rise)
    );
    ufsp_edge u_oscen (
        .i_clk(i_clk), .i_rst(i_rst), .i_async(i_osc_enable),
        .o_level(osc_en_lvl), .o_rise()
    );

    // tap address held stable by the tap around its strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tap_addr_m <= '0;
            tap_addr_s <= '0;
        end else begin
            tap_addr_m <= i_tap_addr;
            tap_addr_s <= tap_addr_m;
        end
    end

    // tap write word, same two-stage delay as the strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tap_wdata_m <= '0;
            tap_wdata_s <= '0;
        end else begin
            tap_wdata_m <= i_tap_wdata;
            tap_wdata_s <= tap_wdata_m;
        end
    end

    // address register, frozen while busy
    // a clock that lands while busy is lost, not deferred
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            addr <= ufsp_pkg::ADDR_FIRST;
        end else if (aclk_rise && !busy) begin
            if (ashift) begin
                addr <= {addr[AW-2:0], aserial}; // [RQ15]
            end else begin
                addr <= addr + 9'h001; // [RQ12] [RQ11]
            end
        end
    end

    // data register; shifts msb first, input enters at lsb
    // load and shift refused while busy so an op sees a steady word
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            data <= '0;
        end else if (dclk_rise && !busy) begin
            if (dshift) begin
                data <= {data[DW-2:0], dserial}; // [RQ16]
            end else begin
                data <= mem[addr]; // [RQ16] [RQ11]
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            data_out_q <= '0;
        end else begin
            data_out_q <= data;
        end
    end

    assign o_data_serial_out = data_out_q[DW-1];

    // program / erase sequencer, timed on oscillator ticks
    assign busy = state == ufsp_pkg::UFSP_PROG
        || state == ufsp_pkg::UFSP_ERASE;
    // the tick after the count reaches zero ends the operation
    assign op_done = osc_link.tick && op_cnt == 32'd0;
    assign erase_fire = op_done && state == ufsp_pkg::UFSP_ERASE;
    assign prog_fire = op_done && state == ufsp_pkg::UFSP_PROG;

    // operation state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ufsp_pkg::UFSP_IDLE;
        end else begin
            case (state)
                ufsp_pkg::UFSP_IDLE: begin
                    if (prog_lvl) begin // [RQ6]
                        state <= ufsp_pkg::UFSP_PROG;
                    end else if (erase_lvl) begin // [RQ6]
                        state <= ufsp_pkg::UFSP_ERASE;
                    end
                end
                ufsp_pkg::UFSP_PROG, ufsp_pkg::UFSP_ERASE: begin
                    if (op_done) begin
                        state <= ufsp_pkg::UFSP_DONE; // [RQ8]
                    end
                end
                ufsp_pkg::UFSP_DONE: begin
                    // wait for the request to drop so one hold = one op
                    if (!prog_lvl && !erase_lvl) begin // [RQ7]
                        state <= ufsp_pkg::UFSP_IDLE;
                    end
                end
                default: begin
                    state <= ufsp_pkg::UFSP_IDLE;
                end
            endcase
        end
    end

    // tick countdown; loaded in idle so each op is timed in full
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            op_cnt <= 32'd0;
        end else if (state == ufsp_pkg::UFSP_IDLE) begin
            if (prog_lvl) begin
                op_cnt <= 32'(PROG_CYCLES / ufsp_pkg::OSC_TICK_CYC);
            end else begin
                op_cnt <= 32'(ERASE_CYCLES / ufsp_pkg::OSC_TICK_CYC);
            end
        end else if (busy && osc_link.tick && !op_done) begin
            op_cnt <= op_cnt - 32'd1;
        end
    end

    // address and data latched as the request is taken
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            op_addr <= '0;
            op_data <= '0;
        end else if (state == ufsp_pkg::UFSP_IDLE) begin
            op_addr <= addr;
            op_data <= data;
        end
    end

    assign o_runtime_prog_busy = busy; // [RQ8]

    // array storage: flash program can only clear bits
    // erase outranks program and tap writes in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < ufsp_pkg::WORDS; gi++) begin : g_word
            localparam logic [AW-1:0] WA = AW'(gi);
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    mem[gi] <= ufsp_pkg::ERASED_WORD;
                end else if (erase_fire && WA[ufsp_pkg::SECTOR_BIT]
                    == op_addr[ufsp_pkg::SECTOR_BIT]) begin
                    mem[gi] <= ufsp_pkg::ERASED_WORD; // [RQ4] [RQ2] [RQ5]
                end else if (prog_fire && WA == op_addr) begin
                    mem[gi] <= mem[gi] & op_data;
                end else if (tap_we_rise && !busy && WA == tap_addr_s) begin
                    mem[gi] <= mem[gi] & tap_wdata_s; // [RQ14]
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tap_rdata <= '0;
        end else if (!tap_we_lvl) begin
            o_tap_rdata <= mem[tap_addr_s]; // [RQ14]
        end
    end
endmodule // ufsp_top

// ---- design/ufsp_pkg.sv ----
// Purpose: shared constants and types of the user flash serial port
// Assumes: 100 MHz system clock
// Notes: array geometry, sector split and timing counts
package ufsp_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int WORDS = 512;
    localparam logic [8:0] ADDR_FIRST = 9'h000;
    localparam logic [8:0] ADDR_LAST = 9'h1ff;
    localparam logic [8:0] SEC0_LAST = 9'h0ff;
    localparam logic [8:0] SEC1_FIRST = 9'h100;
    localparam int SECTOR_BIT = 8;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam int SYS_CLK_MHZ = 100;
    // internal oscillator modelled at 20 MHz, exported divided by 4 = 5 MHz
    localparam int OSC_MHZ = 20;
    localparam int OSC_DIV = 4;
    localparam int OSC_TICK_CYC = SYS_CLK_MHZ / OSC_MHZ;
    localparam int OUT_HALF_CYC = OSC_TICK_CYC * OSC_DIV / 2;
    localparam int PROG_TIME_US = 100;
    localparam int ERASE_TIME_US = 500;
    localparam int PROG_CYC = PROG_TIME_US * SYS_CLK_MHZ;
    localparam int ERASE_CYC = ERASE_TIME_US * SYS_CLK_MHZ;
    typedef enum logic [1:0] {
        UFSP_IDLE,
        UFSP_PROG,
        UFSP_ERASE,
        UFSP_DONE
    } ufsp_state_t;
endpackage

// ---- design/ufsp_osc_if.sv ----
// Purpose: carries the oscillator tick between the main module and divider
// Assumes: single clock domain
// Notes: tick is a one-cycle enable pulse
interface ufsp_osc_if;
    logic enable;
    logic tick;
    logic clk_out;
    modport gen (input enable, output tick, output clk_out);
    modport use_ (output enable, input tick, input clk_out);
endinterface

// ---- design/ufsp_osc.sv ----
// Purpose: internal oscillator model and divide-by-4 clock output
// Assumes: one system clock, slower rates as enable pulses
// Notes: frequency fixed by package constants
module ufsp_osc #(
    parameter int TICK_CYC = ufsp_pkg::OSC_TICK_CYC,
    parameter int HALF_CYC = ufsp_pkg::OUT_HALF_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // oscillator link
    ufsp_osc_if.gen osc
);
    logic [7:0] tick_cnt;
    logic [7:0] half_cnt;
    logic clk_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt <= 8'h00;
        end else if (!osc.enable || tick_cnt == 8'(TICK_CYC - 1)) begin
            tick_cnt <= 8'h00;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end

    assign osc.tick = osc.enable && tick_cnt == 8'(TICK_CYC - 1);

    // divided output stops low when disabled
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            half_cnt <= 8'h00;
            clk_q <= 1'b0;
        end else if (!osc.enable) begin // [RQ17]
            half_cnt <= 8'h00;
            clk_q <= 1'b0;
        end else if (half_cnt == 8'(HALF_CYC - 1)) begin // [RQ9]
            half_cnt <= 8'h00;
            clk_q <= ~clk_q;
        end else begin
            half_cnt <= half_cnt + 8'h01;
        end
    end

    assign osc.clk_out = clk_q;
endmodule // ufsp_osc

// ---- design/ufsp_edge.sv ----
// Purpose: two-flop synchroniser with rising edge pulse
// Assumes: asynchronous input, one system clock
// Notes: first flop read only by the second
module ufsp_edge (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // signal
    input wire logic i_async,
    output logic o_level,
    output logic o_rise
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= i_async;
            sync <= meta;
            prev <= sync;
        end
    end

    assign o_level = sync;
    assign o_rise = sync && !prev;
endmodule // ufsp_edge

// ---- testbench/ufsp_top_chk.sv ----
// Purpose: port checker for the user flash serial port
// Assumes: one clock, async active-high reset
// Notes: counts held in small counters, not long repetitions
module ufsp_top_chk #(
    parameter int PROG_CYCLES = 50,
    parameter int ERASE_CYCLES = 100
) (
    // watched ports
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_data_shift_clk,
    input wire logic o_data_serial_out,
    input wire logic i_program,
    input wire logic i_erase,
    input wire logic o_runtime_prog_busy,
    input wire logic i_osc_enable,
    input wire logic o_osc_div_clk_out
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    int busy_cnt;
    int dclk_age;
    int low_cnt;
    logic dclk_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) busy_cnt <= 0;
        else busy_cnt <= o_runtime_prog_busy ? busy_cnt + 1 : 0;
    end
    // saturates so a long quiet spell never wraps
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) dclk_q <= 1'b0;
        else dclk_q <= i_data_shift_clk;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) dclk_age <= 99;
        else if (i_data_shift_clk && !dclk_q) dclk_age <= 0;
        else if (dclk_age < 99) dclk_age <= dclk_age + 1;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) low_cnt <= 0;
        else if (!i_osc_enable || o_osc_div_clk_out) low_cnt <= 0;
        else low_cnt <= low_cnt + 1;
    end
    a_busy_cause: assert property (
        $rose(o_runtime_prog_busy) |->
        $past(i_program, 2) || $past(i_erase, 2))
        else $error("busy rose without a request");
    a_busy_start: assert property (
        $rose(i_program || i_erase) && !o_runtime_prog_busy |->
        ##[1:6] o_runtime_prog_busy)
        else $error("busy did not follow the request");
    a_busy_min: assert property (
        $rose(o_runtime_prog_busy) |-> o_runtime_prog_busy [*8])
        else $error("busy dropped early");
    a_busy_bound: assert property (
        busy_cnt <= ERASE_CYCLES + 20)
        else $error("busy held too long");
    a_busy_timed: assert property (
        $fell(o_runtime_prog_busy) |-> busy_cnt >= PROG_CYCLES - 5)
        else $error("operation finished too soon");
    a_osc_off: assert property (
        !i_osc_enable [*6] |-> !o_osc_div_clk_out)
        else $error("divided clock runs while disabled");
    a_osc_half: assert property (
        disable iff (i_rst || !i_osc_enable)
        $rose(o_osc_div_clk_out) |-> ##9 o_osc_div_clk_out ##1
        !o_osc_div_clk_out)
        else $error("divided clock high phase wrong");
    a_osc_runs: assert property (
        low_cnt <= 20)
        else $error("divided clock stuck low");
    a_dout_cause: assert property (
        $changed(o_data_serial_out) |-> dclk_age <= 8)
        else $error("serial out moved without data clock");
endmodule // ufsp_top_chk

bind ufsp_top ufsp_top_chk #(
    .PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
) i_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_data_shift_clk(i_data_shift_clk),
    .o_data_serial_out(o_data_serial_out), .i_program(i_program),
    .i_erase(i_erase), .o_runtime_prog_busy(o_runtime_prog_busy),
    .i_osc_enable(i_osc_enable), .o_osc_div_clk_out(o_osc_div_clk_out));

// ---- testbench/ufsp_user.sv ----
// Purpose: user logic model driving the serial flash port
// Assumes: pins change on the falling system clock edge
// Notes: each clock stays high 5 cycles and low at least 10, above the 3-cycle floor
module ufsp_user (
    // clock and observed outputs
    input wire logic i_clk,
    input wire logic i_dout,
    input wire logic i_busy,
    // driven pins
    output logic o_aclk,
    output logic o_actl,
    output logic o_ain,
    output logic o_dclk,
    output logic o_dctl,
    output logic o_din,
    output logic o_prog,
    output logic o_erase
);
    initial begin
        {o_aclk, o_actl, o_ain, o_dclk} = 4'h0;
        {o_dctl, o_din, o_prog, o_erase} = 4'h0;
    end
    task automatic pulse(input logic dat, input logic ctl, input logic b);
        @(negedge i_clk);
        if (dat) {o_dctl, o_din} = {ctl, b};
        else {o_actl, o_ain} = {ctl, b};
        repeat (4) @(negedge i_clk);
        if (dat) o_dclk = 1'b1;
        else o_aclk = 1'b1;
        repeat (5) @(negedge i_clk);
        if (dat) o_dclk = 1'b0;
        else o_aclk = 1'b0;
        repeat (5) @(negedge i_clk);
        // spent serial bit flips so a stale level cannot pass
        if (dat) o_din = ~b;
        else o_ain = ~b;
    endtask
    task automatic set_addr(input logic [8:0] a);
        for (int i = 8; i >= 0; i--) pulse(1'b0, 1'b1, a[i]);
    endtask
    task automatic step_addr;
        pulse(1'b0, 1'b0, 1'b0);
    endtask
    task automatic read_word(output logic [15:0] w);
        pulse(1'b1, 1'b0, 1'b0);
        for (int i = 15; i >= 0; i--) begin
            w[i] = i_dout;
            pulse(1'b1, 1'b1, 1'b0);
        end
    endtask
    task automatic load_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) pulse(1'b1, 1'b1, w[i]);
    endtask
    task automatic request(input logic ers, output int n);
        n = 0;
        @(negedge i_clk);
        if (ers) o_erase = 1'b1;
        else o_prog = 1'b1;
        for (int i = 0; i < 20 && i_busy !== 1'b1; i++) @(negedge i_clk);
        while (i_busy === 1'b1 && n < 5000) begin
            @(negedge i_clk);
            n++;
        end
        {o_prog, o_erase} = 2'h0;
        repeat (5) @(negedge i_clk);
    endtask
endmodule // ufsp_user

// ---- testbench/tb_ufsp_top.sv ----
// Purpose: self-checking bench for the user flash serial port
// Assumes: short program and erase counts
// Notes: test path used only to seed and inspect the array
module tb_ufsp_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 50;
    localparam int E = 100;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic aclk, actl, ain, dclk, dctl, din, dout;
    logic prog, ers, busy, osc_en, osc, twe;
    logic [8:0] taddr;
    logic [15:0] twd, trd;
    int error_cnt = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    ufsp_top #(.PROG_CYCLES(P), .ERASE_CYCLES(E)) i_dut (
        .i_clk(clk), .i_rst(rst), .i_addr_shift_clk(aclk),
        .i_addr_shift_ctl(actl), .i_addr_serial_in(ain),
        .i_data_shift_clk(dclk), .i_data_shift_ctl(dctl),
        .i_data_serial_in(din), .o_data_serial_out(dout),
        .i_program(prog), .i_erase(ers), .o_runtime_prog_busy(busy),
        .i_osc_enable(osc_en), .o_osc_div_clk_out(osc), .i_tap_we(twe),
        .i_tap_addr(taddr), .i_tap_wdata(twd), .o_tap_rdata(trd));
    ufsp_user i_user (.i_clk(clk), .i_dout(dout), .i_busy(busy),
        .o_aclk(aclk), .o_actl(actl), .o_ain(ain), .o_dclk(dclk),
        .o_dctl(dctl), .o_din(din), .o_prog(prog), .o_erase(ers));
    task automatic check(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tap_wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge clk);
        {taddr, twd} = {a, d};
        repeat (4) @(negedge clk);
        twe = 1'b1;
        repeat (5) @(negedge clk);
        twe = 1'b0;
        repeat (5) @(negedge clk);
    endtask
    task automatic tap_rd(input logic [8:0] a, input logic [15:0] exp);
        @(negedge clk);
        taddr = a;
        repeat (6) @(negedge clk);
        check("tap word", trd, exp);
    endtask
    task automatic busy_len(input int n, input int lim);
        check("busy span", {15'h0000, n >= lim - 5 && n <= lim + 10},
            16'h0001);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // about 2000 cycles of traffic; tenfold margin
    initial begin
        #200000;
        error_cnt++;
        results();
    end
    initial begin
        logic [15:0] w;
        int n;
        int hi;
        int lo;
        {osc_en, twe, taddr, twd} = {2'h0, 9'h000, 16'h0000};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        tap_rd(9'h000, 16'hffff);
        tap_rd(9'h1ff, 16'hffff);
        tap_wr(9'h0ff, 16'h1234);
        tap_wr(9'h100, 16'habcd);
        i_user.set_addr(9'h0ff);
        i_user.read_word(w);
        check("serial word", w, 16'h1234);
        i_user.step_addr();
        i_user.read_word(w);
        check("stream word", w, 16'habcd);
        i_user.set_addr(9'h0ff);
        i_user.request(1'b1, n);
        busy_len(n, E);
        tap_rd(9'h0ff, 16'hffff);
        tap_rd(9'h100, 16'habcd);
        i_user.load_word(16'h5a5a);
        i_user.request(1'b0, n);
        busy_len(n, P);
        tap_rd(9'h0ff, 16'h5a5a);
        tap_rd(9'h100, 16'habcd);
        i_user.set_addr(9'h1ff);
        i_user.request(1'b1, n);
        busy_len(n, E);
        tap_rd(9'h100, 16'hffff);
        i_user.set_addr(9'h0fe);
        i_user.step_addr();
        i_user.read_word(w);
        check("stepped word", w, 16'h5a5a);
        repeat (30) @(negedge clk);
        check("osc idle", {15'h0000, osc}, 16'h0000);
        osc_en = 1'b1;
        {hi, lo} = {32'h0, 32'h0};
        for (int i = 0; i < 60 && osc !== 1'b1; i++) @(negedge clk);
        while (osc === 1'b1 && hi < 60) begin
            @(negedge clk);
            hi++;
        end
        while (osc === 1'b0 && lo < 60) begin
            @(negedge clk);
            lo++;
        end
        check("osc high", 16'(hi), 16'h000a);
        check("osc low", 16'(lo), 16'h000a);
        osc_en = 1'b0;
        repeat (20) @(negedge clk);
        check("osc stopped", {15'h0000, osc}, 16'h0000);
        results();
    end
endmodule // tb_ufsp_top
